/* File: hw/vfd_driver.sv */
// Summary of operation
// - serial clock rise shifts all 40 stages
// - serial out is stage 40 up, 1 down
// - latch holds while strobe low
// - strobe high passes stages, falling edge holds
// - blank forces low, test forces high unless blanked
// - direction and blank default high, test low
// - shift stages have no reset
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module vfd_driver
    import vfd_pkg::*;
#(
    parameter int N = VFD_STAGES
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic         serial_clk,
    input  wire logic         serial_in,
    input  wire logic         shift_dir,
    input  wire logic         latch_strobe,
    input  wire logic         blank_n,
    input  wire logic         all_on_test,
    output logic              serial_out,
    output logic [N-1:0]      drive_out,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr
);
    // ---------------------------------------------------------------
    // pin sampling
    // ---------------------------------------------------------------
    logic sclk_q, sclk_d;
    logic dir_q, dir_d;
    logic blank_n_q, blank_n_d;
    logic test_q, test_d;
    logic sclk_rise;

    always_comb begin
        sclk_d    = serial_clk;
        dir_d     = shift_dir;
        blank_n_d = blank_n;
        test_d    = all_on_test;
    end

    // reset levels match the pad pulls, as if the pins float
    always_ff @(posedge clk) begin
        if (reset) begin
            sclk_q    <= 1'h0;
            dir_q     <= VFD_DIR_DFLT;
            blank_n_q <= VFD_BLANK_DFLT;
            test_q    <= VFD_TEST_DFLT;
        end else begin
            sclk_q    <= sclk_d;
            dir_q     <= dir_d;
            blank_n_q <= blank_n_d;
            test_q    <= test_d;
        end
    end

    // direction taken from the pin at the edge, not a cycle late
    assign sclk_rise = serial_clk & ~sclk_q;

    // ---------------------------------------------------------------
    // shift register
    // ---------------------------------------------------------------
    logic [N-1:0] stage_bits;

    vfd_shift_chain #(.N(N)) u_chain (
        .clk        (clk),
        .shift_en   (sclk_rise),
        .dir_up     (shift_dir),
        .din        (serial_in),
        .stage_bits (stage_bits)
    );

    // ---------------------------------------------------------------
    // latch and output stage
    // ---------------------------------------------------------------
    logic [N-1:0] latch_out, latch_d;
    logic [N-1:0] drive_d;
    logic         serial_d;
    logic         sw_blank_q, sw_blank_d;

    always_comb begin
        latch_d = latch_strobe ? stage_bits : latch_out;
        serial_d = shift_dir ? stage_bits[N-1] : stage_bits[0];
        // software blank adds to the pin so boot stays dark
        if (!blank_n_q || sw_blank_q) begin
            drive_d = '0;
        end else if (test_q) begin
            drive_d = '1;
        end else begin
            drive_d = latch_out;
        end
    end

    // latch is data like the chain: no reset, unlike the outputs, sampled pins and apb registers
    always_ff @(posedge clk) begin
        latch_out <= latch_d;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            serial_out <= 1'h0;
            drive_out  <= '0;
        end else begin
            serial_out <= serial_d;
            drive_out  <= drive_d;
        end
    end

    // ---------------------------------------------------------------
    // apb slave
    // ---------------------------------------------------------------
    logic [31:0] prdata_d;
    logic        pready_d, pslverr_d;
    logic        setup, wr_go;

    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a == VFD_CTRL_OFS)  || (a == VFD_PINS_OFS)  ||
                     (a == VFD_STGLO_OFS) || (a == VFD_STGHI_OFS) ||
                     (a == VFD_LATLO_OFS) || (a == VFD_LATHI_OFS);
    endfunction : addr_known

    function automatic logic [31:0] hi_word(input logic [N-1:0] v);
        logic [63:0] w;
        w = 64'h0;
        w[N-1:0] = v;
        hi_word = {8'h00, w[55:32]} & 32'h000000FF;
    endfunction : hi_word

    assign setup = psel & ~penable;
    assign wr_go = psel & penable & pready & pwrite & ~pslverr;

    always_comb begin
        prdata_d   = 32'h0;
        pready_d   = setup;
        pslverr_d  = setup & ~addr_known(paddr);
        sw_blank_d = sw_blank_q;
        if (setup && !pwrite) begin
            case (paddr)
                VFD_CTRL_OFS:  prdata_d[VFD_CTRL_BLANK] = sw_blank_q;
                VFD_PINS_OFS: begin
                    prdata_d[VFD_PIN_DIR]    = dir_q;
                    prdata_d[VFD_PIN_BLANK]  = blank_n_q;
                    prdata_d[VFD_PIN_TEST]   = test_q;
                    prdata_d[VFD_PIN_STROBE] = latch_strobe;
                end
                VFD_STGLO_OFS: prdata_d = stage_bits[31:0];
                VFD_STGHI_OFS: prdata_d = hi_word(stage_bits);
                VFD_LATLO_OFS: prdata_d = latch_out[31:0];
                VFD_LATHI_OFS: prdata_d = hi_word(latch_out);
                default:       prdata_d = 32'h0;
            endcase
        end else if (psel && penable) begin
            prdata_d = prdata;
        end
        if (wr_go && paddr == VFD_CTRL_OFS) begin
            sw_blank_d = pwdata[VFD_CTRL_BLANK];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            prdata     <= 32'h0;
            pready     <= 1'h0;
            pslverr    <= 1'h0;
            sw_blank_q <= VFD_CTRL_RST;
        end else begin
            prdata     <= prdata_d;
            pready     <= pready_d;
            pslverr    <= pslverr_d;
            sw_blank_q <= sw_blank_d;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    // case equality: unfilled stages stay unknown until a full frame
    chk_shift_up: assert property (@(posedge clk) disable iff (reset)
        sclk_rise && shift_dir |=>
            stage_bits === {$past(stage_bits[N-2:0]), $past(serial_in)})
        else $error("upward shift wrong");
    chk_shift_down: assert property (@(posedge clk) disable iff (reset)
        sclk_rise && !shift_dir |=>
            stage_bits === {$past(serial_in), $past(stage_bits[N-1:1])})
        else $error("downward shift wrong");
    chk_shift_idle: assert property (@(posedge clk) disable iff (reset)
        !sclk_rise |=> stage_bits === $past(stage_bits))
        else $error("stages moved without serial clock rise");
    chk_serial_tap: assert property (@(posedge clk) disable iff (reset)
        ##1 serial_out === ($past(shift_dir) ? $past(stage_bits[N-1])
                                             : $past(stage_bits[0])))
        else $error("serial out taps wrong stage");
    chk_latch_hold: assert property (@(posedge clk) disable iff (reset)
        !latch_strobe |=> latch_out === $past(latch_out))
        else $error("latch changed with strobe low");
    chk_latch_pass: assert property (@(posedge clk) disable iff (reset)
        latch_strobe |=> latch_out === $past(stage_bits))
        else $error("latch not transparent");
    chk_blank_low: assert property (@(posedge clk) disable iff (reset)
        !blank_n_q |=> drive_out == '0)
        else $error("outputs not blanked");
    chk_test_high: assert property (@(posedge clk) disable iff (reset)
        blank_n_q && test_q && !sw_blank_q |=> drive_out == '1)
        else $error("test did not light all outputs");
    chk_pin_dflt: assert property (@(posedge clk) disable iff (reset)
        $fell(reset) |-> dir_q && blank_n_q && !test_q)
        else $error("pin defaults wrong after reset");
endmodule : vfd_driver

`default_nettype wire

/* File: hw/vfd_shift_chain.sv */
// ---------------------------------------------------------------
// shared constants
// ---------------------------------------------------------------
package vfd_pkg;
    localparam int          VFD_STAGES     = 40;
    localparam logic [7:0]  VFD_CTRL_OFS   = 8'h00;
    localparam logic [7:0]  VFD_PINS_OFS   = 8'h04;
    localparam logic [7:0]  VFD_STGLO_OFS  = 8'h08;
    localparam logic [7:0]  VFD_STGHI_OFS  = 8'h0C;
    localparam logic [7:0]  VFD_LATLO_OFS  = 8'h10;
    localparam logic [7:0]  VFD_LATHI_OFS  = 8'h14;
    localparam int          VFD_CTRL_BLANK = 0;
    localparam logic        VFD_CTRL_RST   = 1'h1;
    localparam int          VFD_PIN_DIR    = 0;
    localparam int          VFD_PIN_BLANK  = 1;
    localparam int          VFD_PIN_TEST   = 2;
    localparam int          VFD_PIN_STROBE = 3;
    localparam logic        VFD_DIR_DFLT   = 1'h1;
    localparam logic        VFD_BLANK_DFLT = 1'h1;
    localparam logic        VFD_TEST_DFLT  = 1'h0;
endpackage : vfd_pkg

`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// bidirectional shift chain
// ---------------------------------------------------------------
module vfd_shift_chain
    import vfd_pkg::*;
#(
    parameter int N = VFD_STAGES
) (
    input  wire logic         clk,
    input  wire logic         shift_en,
    input  wire logic         dir_up,
    input  wire logic         din,
    output logic [N-1:0]      stage_bits
);
    logic [N-1:0] stage_d;

    // no reset on purpose: contents are unknown until shifted
    always_comb begin
        if (!shift_en) begin
            stage_d = stage_bits;
        end else if (dir_up) begin
            stage_d = {stage_bits[N-2:0], din};
        end else begin
            stage_d = {din, stage_bits[N-1:1]};
        end
    end

    always_ff @(posedge clk) begin
        stage_bits <= stage_d;
    end
endmodule : vfd_shift_chain

`default_nettype wire

/* File: testbench/vfd_driver_test.sv */
`timescale 1ns/1ps
`default_nettype none

module vfd_driver_test;
    import vfd_pkg::*;
    logic        clk, reset, psel, penable, pwrite, pready, pslverr;
    logic        sclk, sin, sdir, stb, blank_n, test, serial_out;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic [39:0] drive_out;
    logic        e;
    int          fail_count, num_checks, cycles;
    localparam logic [39:0] P = 40'hA50F3C9661;
    localparam logic [39:0] Q = 40'h9E3779B97F;

    vfd_host_model i_vfd_host_model (.clk(clk), .serial_clk(sclk),
        .serial_in(sin), .shift_dir(sdir), .latch_strobe(stb),
        .blank_n(blank_n), .all_on_test(test));
    vfd_driver i_vfd_driver (.clk(clk), .reset(reset), .serial_clk(sclk),
        .serial_in(sin), .shift_dir(sdir), .latch_strobe(stb),
        .blank_n(blank_n), .all_on_test(test), .serial_out(serial_out),
        .drive_out(drive_out), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [39:0] s, input logic [39:0] x);
        num_checks++;
        if (s !== x) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel    <= 1'h1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        // only the bench timeout ends this wait
        while (pready !== 1'h1) begin
            @(posedge clk);
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask : apb

    task automatic t_reset();
        chk(drive_out, '0);
        apb(1'h0, VFD_CTRL_OFS, '0);
        chk(40'(r), 40'h1);
        apb(1'h0, VFD_PINS_OFS, '0);
        chk(40'(r), 40'h1);
        apb(1'h0, 8'h20, '0);
        chk(40'({r[7:0], e}), 40'h1);
    endtask : t_reset

    task automatic t_load();
        i_vfd_host_model.send(P, 40);
        i_vfd_host_model.strobe();
        i_vfd_host_model.pins(1'h1, 1'h1, 1'h0);
        apb(1'h1, VFD_CTRL_OFS, '0);
        repeat (4) @(posedge clk);
        chk(drive_out, P);
    endtask : t_load

    task automatic t_hold();
        i_vfd_host_model.send(Q, 40);
        repeat (4) @(posedge clk);
        chk(drive_out, P);
        chk(40'(serial_out), 40'(Q[39]));
        apb(1'h0, VFD_STGLO_OFS, '0);
        chk(40'(r), 40'(Q[31:0]));
        apb(1'h0, VFD_STGHI_OFS, '0);
        chk(40'(r), 40'(Q[39:32]));
        apb(1'h0, VFD_LATLO_OFS, '0);
        chk(40'(r), 40'(P[31:0]));
        apb(1'h0, VFD_LATHI_OFS, '0);
        chk(40'(r), 40'(P[39:32]));
        i_vfd_host_model.strobe();
        chk(drive_out, Q);
    endtask : t_hold

    task automatic t_down();
        i_vfd_host_model.pins(1'h0, 1'h1, 1'h0);
        chk(40'(serial_out), 40'(Q[0]));
        i_vfd_host_model.send(40'h0, 1);
        i_vfd_host_model.strobe();
        chk(drive_out, {1'h0, Q[39:1]});
        chk(40'(serial_out), 40'(Q[1]));
    endtask : t_down

    task automatic t_force();
        i_vfd_host_model.pins(1'h0, 1'h1, 1'h1);
        chk(drive_out, '1);
        apb(1'h0, VFD_PINS_OFS, '0);
        chk(40'(r), 40'h6);
        i_vfd_host_model.pins(1'h0, 1'h0, 1'h1);
        chk(drive_out, '0);
        i_vfd_host_model.pins(1'h0, 1'h1, 1'h0);
        chk(drive_out, {1'h0, Q[39:1]});
    endtask : t_force

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test

    // whole run is well under 2000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            end_of_test();
        end
    end

    initial begin
        {reset, psel, penable, pwrite, paddr, pwdata} = '1;
        {psel, penable, pwrite} = 3'h0;
        repeat (6) @(posedge clk);
        reset <= 1'h0;
        @(posedge clk);
        t_reset();
        t_load();
        t_hold();
        t_down();
        t_force();
        end_of_test();
    end
endmodule : vfd_driver_test

`default_nettype wire

/* File: testbench/vfd_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// serial host model
// ---------------------------------------------------------------
module vfd_host_model (
    input  wire logic clk,
    output logic      serial_clk,
    output logic      serial_in,
    output logic      shift_dir,
    output logic      latch_strobe,
    output logic      blank_n,
    output logic      all_on_test
);
    initial begin
        serial_clk   = 1'h0;
        serial_in    = 1'h0;
        shift_dir    = 1'h1;
        latch_strobe = 1'h0;
        blank_n      = 1'h0;
        all_on_test  = 1'h0;
    end

    // data flips after the fall so a stale bit is never taken
    task automatic send(input logic [39:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            serial_in  <= v[i];
            serial_clk <= 1'h1;
            repeat (2) @(posedge clk);
            serial_clk <= 1'h0;
            @(posedge clk);
            serial_in  <= ~v[i];
            @(posedge clk);
        end
    endtask : send

    task automatic strobe();
        latch_strobe <= 1'h1;
        repeat (2) @(posedge clk);
        latch_strobe <= 1'h0;
        repeat (4) @(posedge clk);
    endtask : strobe

    task automatic pins(input logic d, input logic b, input logic t);
        shift_dir   <= d;
        blank_n     <= b;
        all_on_test <= t;
        repeat (4) @(posedge clk);
    endtask : pins
endmodule : vfd_host_model

`default_nettype wire
